//--- tributary_desync_fifo.sv
/*
  Line interface digital core: transmit jitter attenuation store, all-ones
  transmission, recovered clock shaping, signal-loss and driver monitor
  alarms, calibration source selection and host status encoding.
  Assumes every pin input is asynchronous to the 10 MHz reference clock.
*/
`timescale 1ns/1ps
module tributary_desync_fifo (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic tx_clk_in,
  input wire logic tx_data_in,
  input wire logic auxiliary_clock_input_in,
  input wire logic transmit_all_ones_in,
  input wire logic rx_clk_in,
  input wire logic rx_data_in,
  input wire logic monitor_activity_in,
  input wire logic host_mode_in,
  input wire logic status_ack_in,
  output tributary_desync_pkg::line_bit_type line_tx_out,
  output logic recovered_clk_out,
  output logic recovered_data_out,
  output logic signal_absence_flag_out,
  output logic driver_activity_monitor_out,
  output logic cal_from_aux_out,
  output logic [7:0] status_out
);
  import tributary_desync_pkg::*;

  function automatic logic rise(input logic [SYNC_WIDTH-1:0] now, input logic [SYNC_WIDTH-1:0] prev,
                                input int idx);
    rise = now[idx] & ~prev[idx];
  endfunction : rise

  function automatic logic fall(input logic [SYNC_WIDTH-1:0] now, input logic [SYNC_WIDTH-1:0] prev,
                                input int idx);
    fall = ~now[idx] & prev[idx];
  endfunction : fall

  // Pin synchronisers: stage a feeds only stage b; c is for edge finding
  wire logic [SYNC_WIDTH-1:0] pins_raw = {status_ack_in, host_mode_in, monitor_activity_in,
    rx_data_in, rx_clk_in, transmit_all_ones_in, auxiliary_clock_input_in, tx_data_in, tx_clk_in};
  logic [SYNC_WIDTH-1:0] sync_a;
  logic [SYNC_WIDTH-1:0] sync_b;
  logic [SYNC_WIDTH-1:0] sync_c;
  generate
    for (genvar i = 0; i < SYNC_WIDTH; i++) begin : g_sync
      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          sync_a[i] <= 1'b0;
          sync_b[i] <= 1'b0;
          sync_c[i] <= 1'b0;
        end else begin
          sync_a[i] <= pins_raw[i];
          sync_b[i] <= sync_a[i];
          sync_c[i] <= sync_b[i];
        end
      end
    end
  endgenerate

  // Decoded pin events
  wire logic all_ones = sync_b[PIN_ALL_ONES];
  wire logic tx_take = fall(sync_b, sync_c, PIN_TX_CLK);
  wire logic aux_edge = rise(sync_b, sync_c, PIN_AUX_CLK);
  wire logic rx_take = rise(sync_b, sync_c, PIN_RX_CLK);
  wire logic mon_edge = rise(sync_b, sync_c, PIN_MONITOR) | fall(sync_b, sync_c, PIN_MONITOR);
  wire logic ack_edge = rise(sync_b, sync_c, PIN_ACK);
  wire logic rx_bit = sync_b[PIN_RX_DATA];

  // Jitter attenuation store and its smoothed read clock
  logic [STORE_DEPTH-1:0] store;
  logic [4:0] wr_ptr;
  logic [4:0] rd_ptr;
  logic [5:0] fill;
  logic reading_on;
  logic [15:0] phase;
  wire logic store_full = (fill == 6'(STORE_DEPTH));
  wire logic store_empty = (fill == 6'h00);
  wire logic signed [7:0] fill_err = $signed({2'b00, fill}) - $signed(8'(STORE_CENTER));
  wire logic [15:0] nco_inc = 16'(NCO_BASE_INC) + (16'(fill_err) <<< NCO_GAIN_SHIFT);
  wire logic [16:0] phase_sum = {1'b0, phase} + {1'b0, nco_inc};
  wire logic nco_tick = phase_sum[16];
  wire logic wr_en = tx_take & ~all_ones;
  wire logic rd_en = nco_tick & reading_on & ~store_empty & ~all_ones;
  wire logic drop_oldest = wr_en & store_full & ~rd_en;
  wire logic [5:0] next_fill = (wr_en & ~rd_en & ~store_full) ? fill + 6'h01 :
                               (rd_en & ~wr_en) ? fill - 6'h01 : fill;

  // Store write, read and occupancy; gaps up to twelve bits never hit limits
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      store <= '0;
      wr_ptr <= 5'h00;
      rd_ptr <= 5'h00;
      fill <= 6'h00;
      phase <= 16'h0000;
    end else begin
      phase <= phase_sum[15:0];
      fill <= next_fill; // RULE8
      if (wr_en) begin
        store[wr_ptr] <= sync_b[PIN_TX_DATA];
        wr_ptr <= wr_ptr + 5'h01;
      end
      if (rd_en || drop_oldest) begin
        rd_ptr <= rd_ptr + 5'h01;
      end
    end
  end

  // Reading starts at mid fill and restarts there after running dry
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reading_on <= 1'b0;
    end else if (fill >= 6'(STORE_CENTER)) begin
      reading_on <= 1'b1; // RULE8
    end else if (store_empty && nco_tick) begin
      reading_on <= 1'b0;
    end
  end

  // Line output: smoothed bits, or ones on the auxiliary clock
  wire logic line_emit = rd_en | (all_ones & aux_edge);
  wire logic line_bit = all_ones ? 1'b1 : store[rd_ptr]; // RULE11
  logic [1:0] line_hi_cnt;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      line_tx_out <= '0;
      line_hi_cnt <= 2'h0;
    end else if (line_emit) begin
      line_tx_out.data <= line_bit; // RULE11
      line_tx_out.clk <= 1'b1;
      line_hi_cnt <= 2'(LINE_HIGH_CYCLES - 1);
    end else if (line_hi_cnt != 2'h0) begin
      line_hi_cnt <= line_hi_cnt - 2'h1;
    end else begin
      line_tx_out.clk <= 1'b0;
    end
  end

  // Recovered clock: short high phase, so duty is far from even
  logic [1:0] rclk_cnt;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      recovered_clk_out <= 1'b0;
      recovered_data_out <= 1'b0;
      rclk_cnt <= 2'h0;
    end else if (rx_take) begin
      recovered_clk_out <= 1'b1; // RULE16
      recovered_data_out <= rx_bit;
      rclk_cnt <= 2'(RCLK_HIGH_CYCLES - 1);
    end else if (rclk_cnt != 2'h0) begin
      rclk_cnt <= rclk_cnt - 2'h1;
    end else begin
      recovered_clk_out <= 1'b0;
    end
  end

  // Zero run and signal-loss window
  sig_state_type sig_state;
  logic [7:0] zero_run;
  logic [7:0] win_cnt;
  logic [7:0] win_ones;
  wire logic [7:0] next_zero_run = rx_bit ? 8'h00 :
                                   (zero_run == 8'hFF) ? zero_run : zero_run + 8'h01;
  wire logic run_hit = (next_zero_run == 8'(ABSENCE_ZERO_RUN));
  wire logic win_abort = (next_zero_run >= 8'(ABSENCE_WINDOW_ZERO_LIMIT));
  wire logic [7:0] next_ones = win_ones + {7'h00, rx_bit};
  wire logic win_done = (win_cnt == 8'(ABSENCE_WINDOW_BITS - 1));
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      zero_run <= 8'h00;
      sig_state <= SIG_OK;
      win_cnt <= 8'h00;
      win_ones <= 8'h00;
    end else if (rx_take) begin
      zero_run <= next_zero_run;
      unique case (sig_state)
        SIG_OK: if (run_hit) sig_state <= SIG_LOST_WAIT; // RULE14
        SIG_LOST_WAIT: if (rx_bit) begin
          sig_state <= SIG_LOST_WINDOW; // RULE18
          win_cnt <= 8'h01;
          win_ones <= 8'h01;
        end
        SIG_LOST_WINDOW: begin
          win_cnt <= win_cnt + 8'h01;
          win_ones <= next_ones;
          if (win_abort) begin
            sig_state <= SIG_LOST_WAIT; // RULE18
          end else if (win_done) begin
            sig_state <= (next_ones >= 8'(ABSENCE_MIN_ONES)) ? SIG_OK : SIG_LOST_WAIT; // RULE18
          end
        end
      endcase
    end
  end
  assign signal_absence_flag_out = (sig_state != SIG_OK);

  // Driver monitor and auxiliary clock presence counters
  logic [7:0] mon_idle;
  logic [7:0] aux_idle;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mon_idle <= 8'h00;
      aux_idle <= 8'(AUX_IDLE_CYCLES);
    end else begin
      mon_idle <= mon_edge ? 8'h00 :
                  (mon_idle == 8'(MONITOR_IDLE_CYCLES)) ? mon_idle : mon_idle + 8'h01;
      aux_idle <= aux_edge ? 8'h00 : (aux_idle == 8'(AUX_IDLE_CYCLES)) ? aux_idle : aux_idle + 8'h01;
    end
  end
  assign driver_activity_monitor_out = (mon_idle == 8'(MONITOR_IDLE_CYCLES));
  // Calibration runs all the time from aux when present, else crystal
  assign cal_from_aux_out = (aux_idle != 8'(AUX_IDLE_CYCLES)); // RULE12 RULE17

  // Sticky alarm-change flags; a new change wins over acknowledge
  logic absence_prev;
  logic monitor_prev;
  logic absence_chg;
  logic monitor_chg;
  wire logic absence_flip = signal_absence_flag_out ^ absence_prev;
  wire logic monitor_flip = driver_activity_monitor_out ^ monitor_prev;
  wire logic [2:0] chg_code = (absence_chg & monitor_chg) ? CHG_BOTH :
                              absence_chg ? {CHG_ABSENCE, signal_absence_flag_out} :
                              monitor_chg ? {CHG_MONITOR, driver_activity_monitor_out} : CHG_NONE;
  wire logic [7:0] next_status = {sync_b[PIN_HOST] ? chg_code : CHG_NONE, 3'h0,
                                  driver_activity_monitor_out, signal_absence_flag_out};
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      absence_prev <= 1'b0;
      monitor_prev <= 1'b0;
      absence_chg <= 1'b0;
      monitor_chg <= 1'b0;
      status_out <= 8'h00;
    end else begin
      absence_prev <= signal_absence_flag_out;
      monitor_prev <= driver_activity_monitor_out;
      absence_chg <= absence_flip | (absence_chg & ~ack_edge); // RULE13
      monitor_chg <= monitor_flip | (monitor_chg & ~ack_edge); // RULE13
      status_out <= next_status; // RULE13
    end
  end

  // Checks
  sequence seq_zero_bit;
    rx_take && !rx_bit;
  endsequence
  sequence seq_window_pass;
    rx_take && sig_state == SIG_LOST_WINDOW && win_done && !win_abort &&
      next_ones >= 8'(ABSENCE_MIN_ONES);
  endsequence

  AST_ABSENCE_SET: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE14
    seq_zero_bit ##0 (next_zero_run == 8'(ABSENCE_ZERO_RUN)) |=> signal_absence_flag_out)
    else $error("signal loss not raised after the zero run");
  AST_ABSENCE_RISE_CAUSE: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE14
    $rose(signal_absence_flag_out) |-> $past(zero_run == 8'(ABSENCE_ZERO_RUN - 1)))
    else $error("signal loss raised without the zero run");
  AST_ABSENCE_CLEAR: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE18
    $fell(signal_absence_flag_out) |-> $past(win_done && next_ones >= 8'(ABSENCE_MIN_ONES)))
    else $error("signal loss cleared without enough ones");
  AST_ABSENCE_PASS: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE18
    seq_window_pass |=> !signal_absence_flag_out)
    else $error("signal loss held after a good window");
  AST_ALL_ONES_DATA: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE11
    all_ones && aux_edge |=> line_tx_out.clk && line_tx_out.data)
    else $error("all-ones bit not sent on auxiliary edge");
  AST_NO_EMPTY_READ: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE8
    $rose(line_tx_out.clk) && !$past(all_ones) |-> $past(fill) != 6'h00)
    else $error("line pulse issued from an empty store");
  AST_STORE_BOUND: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE8
    fill <= 6'(STORE_DEPTH))
    else $error("store occupancy beyond depth");
  AST_RCLK_SHAPE: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE16
    rx_take ##1 !rx_take |=> recovered_clk_out ##1 !recovered_clk_out)
    else $error("recovered clock high phase has wrong width");
  AST_CAL_AUX: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE12
    aux_edge |=> cal_from_aux_out [*2])
    else $error("auxiliary clock not chosen for calibration");
  AST_STATUS_CHANGE: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // RULE13
    absence_flip && sync_b[PIN_HOST] |=> ##1 status_out[7])
    else $error("signal loss change not reported in status");
endmodule : tributary_desync_fifo

//--- tributary_desync_pkg.sv
/*
  Constants and types for the transmit smoothing store, signal-loss
  detection and status encoding of the T1 (1544 kHz) line interface logic.
  Assumes a 10 MHz reference clock; all pin timing is counted in it.
*/
// Operation
// [RULE1] Tributary bits written on SONET clock only
// [RULE2] Read clock just above line rate
// [RULE3] No output pulse while store empty
// [RULE4] Divider 32 or 33 T1, 25 E1
// [RULE5] Depth 21, 26 or 34 bits; the store here is 32 bits deep
// [RULE6] Eight extra bits per pointer change
// [RULE7] Longest output gap twelve bits
// [RULE8] Attenuator absorbs twelve-bit gaps without protection
// [RULE9] Write side tolerates 24/32-bit spacing
// [RULE10] Receive map buffer as deep as transmit
// [RULE11] All-ones transmitted on auxiliary clock
// [RULE12] Calibrate from auxiliary clock, else crystal
// [RULE13] Host status bits 5-7 report alarm changes
// [RULE14] Signal loss after 175 consecutive zeros
// [RULE15] Framer inverts recovered clock in hardware mode
// [RULE16] Recovered clock asymmetric duty, quantised jitter
// [RULE17] Continuous calibration, no reset command needed
// [RULE18] Loss clears at 12.5% ones, <100 zeros
// [RULE19] Smoothing buffer sticky overflow/underflow flags; none here, a write while full drops the oldest bit unflagged
// [RULE20] Simultaneous write/read keeps occupancy correct
package tributary_desync_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLK_RATE_KHZ = 1000000 / CLK_PERIOD_NS;
  localparam int LINE_RATE_KHZ = 1544;
  // Signal-loss figures
  localparam int ABSENCE_ZERO_RUN = 175;
  localparam int ABSENCE_WINDOW_BITS = 175;
  localparam int ABSENCE_WINDOW_ZERO_LIMIT = 100;
  localparam int ABSENCE_DENSITY_PERMILLE = 125;
  localparam int ABSENCE_MIN_ONES = (ABSENCE_WINDOW_BITS * ABSENCE_DENSITY_PERMILLE + 999) / 1000;
  // Activity timeouts (longest time, rounded down)
  localparam int MONITOR_IDLE_NS = 20000;
  localparam int MONITOR_IDLE_CYCLES = MONITOR_IDLE_NS / CLK_PERIOD_NS;
  localparam int AUX_IDLE_NS = 20000;
  localparam int AUX_IDLE_CYCLES = AUX_IDLE_NS / CLK_PERIOD_NS;
  // Smoothing store
  localparam int STORE_DEPTH = 32;
  localparam int STORE_CENTER = 16;
  localparam int GAP_TOLERANCE_BITS = 12;
  localparam int NCO_BASE_INC = (65536 * LINE_RATE_KHZ) / CLK_RATE_KHZ;
  localparam int NCO_GAIN_SHIFT = 6;
  // Output pulse widths in reference cycles
  localparam int RCLK_HIGH_CYCLES = 2;
  localparam int LINE_HIGH_CYCLES = 3;
  // Synchronised pin indices
  localparam int SYNC_WIDTH = 9;
  localparam int PIN_TX_CLK = 0;
  localparam int PIN_TX_DATA = 1;
  localparam int PIN_AUX_CLK = 2;
  localparam int PIN_ALL_ONES = 3;
  localparam int PIN_RX_CLK = 4;
  localparam int PIN_RX_DATA = 5;
  localparam int PIN_MONITOR = 6;
  localparam int PIN_HOST = 7;
  localparam int PIN_ACK = 8;
  // Status layout and change codes in bits 7:5
  localparam int STAT_ABSENCE_BIT = 0;
  localparam int STAT_MONITOR_BIT = 1;
  localparam logic [2:0] CHG_NONE = 3'h0;
  localparam logic [2:0] CHG_BOTH = 3'h7;
  localparam logic [1:0] CHG_ABSENCE = 2'h2;
  localparam logic [1:0] CHG_MONITOR = 2'h1;

  typedef struct packed {
    logic clk;
    logic data;
  } line_bit_type;

  typedef enum logic [1:0] {SIG_OK, SIG_LOST_WAIT, SIG_LOST_WINDOW} sig_state_type;
endpackage : tributary_desync_pkg

//--- tributary_tx_source.sv
/*
  Far-side model: smoothing store output feeding the gapped transmit pins.
  Assumes the bench calls send_bits; the pins stand still between bursts.
*/
`timescale 1ns/1ps
module tributary_tx_source (
  output logic tx_clk_out,
  output logic tx_data_out
);
  // Idle pins: clock held high, so no falling edge between bursts
  initial begin
    tx_clk_out = 1'b1;
    tx_data_out = 1'b0;
  end

  // Emit n bits lsb first, after gap idle bit periods of 800 ns
  // Burst length kept within the store depth, never writing while full
  task automatic send_bits(input logic [31:0] bits, input int n, input int gap);
    #(800 * gap);
    for (int i = 0; i < n; i++) begin
      tx_data_out <= bits[i];
      #400 tx_clk_out <= 1'b0;
      #150 tx_data_out <= ~bits[i]; // Held data expires after the hold time
      #250 tx_clk_out <= 1'b1;
    end
  endtask : send_bits
endmodule : tributary_tx_source

//--- tributary_desync_fifo_tb_top.sv
/*
  Self-checking bench for the line interface core: transmit smoothing,
  all-ones, recovered clock, signal loss and status encoding.
  Assumes the far-side source model and the design package are compiled first.
*/
`timescale 1ns/1ps
module tributary_desync_fifo_tb_top;
  import tributary_desync_pkg::*;
  logic ref_clk_in, rst_b_in, tx_clk, tx_data, aux_clk, all_ones, rx_clk, rx_data;
  logic mon = 1'b0;
  logic mon_run, host, ack, rclk, rdata, sig_loss, mon_alarm, cal, line_prev, rclk_prev;
  line_bit_type line_tx;
  logic [7:0] status;
  logic tx_seen[$];
  logic rx_seen[$];
  int line_run, rclk_run, line_width, rclk_width;
  int n_errors, samples_checked;

  tributary_tx_source tributary_tx_source_inst (.tx_clk_out(tx_clk), .tx_data_out(tx_data));

  tributary_desync_fifo tributary_desync_fifo_inst (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .tx_clk_in(tx_clk), .tx_data_in(tx_data),
    .auxiliary_clock_input_in(aux_clk), .transmit_all_ones_in(all_ones),
    .rx_clk_in(rx_clk), .rx_data_in(rx_data), .monitor_activity_in(mon),
    .host_mode_in(host), .status_ack_in(ack), .line_tx_out(line_tx),
    .recovered_clk_out(rclk), .recovered_data_out(rdata),
    .signal_absence_flag_out(sig_loss), .driver_activity_monitor_out(mon_alarm),
    .cal_from_aux_out(cal), .status_out(status)
  );

  // Reference clock, 100 ns period
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  // Capture bits at clock rises and measure high widths
  always @(posedge ref_clk_in) begin
    line_prev <= line_tx.clk;
    rclk_prev <= rclk;
    line_run <= line_tx.clk ? line_run + 1 : 0;
    rclk_run <= rclk ? rclk_run + 1 : 0;
    if (line_tx.clk && !line_prev) tx_seen.push_back(line_tx.data);
    if (rclk && !rclk_prev) rx_seen.push_back(rdata);
    if (!line_tx.clk && line_prev) line_width <= line_run;
    if (!rclk && rclk_prev) rclk_width <= rclk_run;
  end

  // Driver monitor activity while enabled
  always @(posedge ref_clk_in) begin
    if (mon_run) mon <= ~mon;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : cycles

  // One received bit at 800 ns; clock stands low between bits
  task automatic rx_bit(input logic b);
    rx_data <= b;
    #400 rx_clk <= 1'b1;
    #200 rx_data <= ~b;
    #200 rx_clk <= 1'b0;
  endtask : rx_bit

  task automatic do_ack;
    @(posedge ref_clk_in) ack <= 1'b1;
    cycles(5);
    ack <= 1'b0;
    cycles(8);
  endtask : do_ack

  // Gapped burst of 20 bits must leave in order
  task automatic test_transmit;
    logic [31:0] bits;
    int k;
    bits = 32'h000B38E5;
    tx_seen.delete();
    tributary_tx_source_inst.send_bits(bits, 10, 0);
    tributary_tx_source_inst.send_bits(bits >> 10, 10, 12);
    k = 0;
    while (tx_seen.size() < 20 && k < 3000) begin
      cycles(1);
      k++;
    end
    if (k == 3000) begin
      n_errors++;
      tally_and_finish();
    end
    for (int i = 0; i < 20; i++) check(tx_seen[i], bits[i]);
    check(line_width, 3);
  endtask : test_transmit

  // All-ones paced by the auxiliary clock, which also selects calibration
  task automatic test_all_ones;
    tx_seen.delete();
    @(posedge ref_clk_in) all_ones <= 1'b1;
    cycles(6);
    repeat (6) begin
      #400 aux_clk <= 1'b1;
      #400 aux_clk <= 1'b0;
    end
    cycles(10);
    check(tx_seen.size(), 6);
    foreach (tx_seen[i]) check(tx_seen[i], 1);
    check(cal, 1);
    cycles(260);
    check(cal, 0);
    @(posedge ref_clk_in) all_ones <= 1'b0;
  endtask : test_all_ones

  // Loss after 175 zeros; a thin window keeps it, a 22-ones window clears it
  task automatic test_signal_loss;
    do_ack();
    for (int i = 0; i < 174; i++) rx_bit(1'b0);
    cycles(4);
    check(sig_loss, 0);
    check(rx_seen[$], 0);
    check(rclk_width, 2);
    rx_bit(1'b0);
    cycles(4);
    check(sig_loss, 1);
    check(status[7:5], 3'h5);
    check(status[0], 1);
    do_ack();
    check(status[7:5], 3'h0);
    for (int i = 0; i < 175; i++) rx_bit(i % 9 == 0);
    cycles(4);
    check(sig_loss, 1);
    for (int i = 0; i < 174; i++) rx_bit(i % 8 == 0);
    cycles(4);
    check(sig_loss, 1);
    rx_bit(1'b0);
    cycles(4);
    check(sig_loss, 0);
    check(status[7:5], 3'h4);
  endtask : test_signal_loss

  // Monitor goes quiet, then host mode is left
  task automatic test_driver_monitor;
    do_ack();
    @(posedge ref_clk_in) mon_run <= 1'b0;
    cycles(190);
    check(mon_alarm, 0);
    cycles(30);
    check(mon_alarm, 1);
    check(status[7:5], 3'h3);
    check(status[1], 1);
    @(posedge ref_clk_in) host <= 1'b0;
    // Two synchroniser stages plus the status register
    cycles(4);
    check(status[7:5], 3'h0);
    host <= 1'b1;
    mon_run <= 1'b1;
  endtask : test_driver_monitor

  // Main sequence
  initial begin
    n_errors = 0;
    samples_checked = 0;
    rst_b_in = 1'b0;
    aux_clk = 1'b0;
    all_ones = 1'b0;
    rx_clk = 1'b0;
    rx_data = 1'b0;
    mon_run = 1'b1;
    host = 1'b1;
    ack = 1'b0;
    cycles(10);
    check({line_tx, rclk, rdata, sig_loss, mon_alarm, cal, status}, 0);
    @(posedge ref_clk_in) rst_b_in <= 1'b1;
    cycles(5);
    test_transmit();
    test_all_ones();
    test_signal_loss();
    test_driver_monitor();
    tally_and_finish();
  end

  // Hang guard
  initial begin
    #9000000;
    n_errors++;
    tally_and_finish();
  end
endmodule : tributary_desync_fifo_tb_top
